// ==== odsl_pkg.sv ====
// Constants and types shared by the octal DAC serial loader.
// Assumes it is compiled before every other file of the block.
package odsl_pkg;

   localparam int           NUM_CHAN     = 8;
   localparam int           ADDR_BITS    = 3;
   localparam int           VALUE_BITS   = 8;
   localparam int           WORD_BITS    = ADDR_BITS + VALUE_BITS;
   localparam int           ADDR_MSB_POS = WORD_BITS - 1;
   localparam int           ADDR_LSB_POS = VALUE_BITS;
   localparam int           LANE_SHIFT   = 3;

   localparam logic [WORD_BITS-1:0]           LINK_WORD_RST = 11'h000;
   localparam logic [VALUE_BITS-1:0]          MIDSCALE      = 8'h80;
   localparam logic [NUM_CHAN*VALUE_BITS-1:0] CHAN_OUT_RST  =
      {NUM_CHAN{MIDSCALE}};
   localparam logic [NUM_CHAN-1:0]            OE_N_RST      = 8'h00;
   localparam logic [NUM_CHAN-1:0]            UPDATE_RST    = 8'h00;
   localparam logic [NUM_CHAN-1:0]            ONE_HOT_BASE  = 8'h01;

   // Cycles of ref_clk from the synchronised select rise to the latch load.
   localparam int           COMMIT_LATENCY = 2;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_FRAME  = 2'b01,
      ST_COMMIT = 2'b10
   } odsl_state_e;

endpackage

// ==== odsl_sync.sv ====
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that stays put for several clock periods.
module odsl_sync
   import odsl_pkg::*;
#(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  logic             clk_i,
   input  logic             rst_n_i,
   input  logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= RESET_VAL;
         q_o  <= RESET_VAL;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule

// ==== odsl_shift.sv ====
// Serial input register clocked by the controller's serial clock.
// Assumes select and data are launched by the controller against that clock.
module odsl_shift
   import odsl_pkg::*;
(
   input  logic                 serial_clk_i,
   input  logic                 rst_n_i,
   input  logic                 select_n_i,
   input  logic                 serial_in_i,
   output logic [WORD_BITS-1:0] word_o
);

   // Only the newest bits survive, so long byte-padded frames still work.
   always_ff @(posedge serial_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_o <= LINK_WORD_RST;
      end else if (!select_n_i) begin
         word_o <= {word_o[WORD_BITS-2:0], serial_in_i};
      end
   end

   default clocking cb @(posedge serial_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_shift_takes_bit: assert property (
      !select_n_i |=> word_o[0] == $past(serial_in_i)
                      && word_o[WORD_BITS-1:1] == $past(word_o[WORD_BITS-2:0]))
      else $error("serial register did not shift in the data bit");

   a_idle_no_shift: assert property (
      select_n_i |=> $stable(word_o))
      else $error("serial register changed while select was high");

   a_oldest_dropped: assert property (
      (!select_n_i) [*2] |=> word_o[WORD_BITS-1] == $past(word_o[WORD_BITS-3], 2))
      else $error("oldest bits were not dropped from the serial register");

endmodule

// ==== odsl_top.sv ====
// Serial load logic of an eight channel 8-bit DAC.
// Assumes the controller holds the serial clock high when select rises and
// may run the serial clock while select is high, which shifts nothing.
module odsl_top
   import odsl_pkg::*;
(
   input  logic                           ref_clk_i,
   input  logic                           rst_n_i,
   input  logic                           serial_clk_i,
   input  logic                           select_n_i,
   input  logic                           serial_in_i,
   input  logic                           preset_n_i,
   input  logic                           powerdown_n_i,
   output logic [NUM_CHAN*VALUE_BITS-1:0] channel_outputs_o,
   output logic [NUM_CHAN-1:0]            channel_outputs_oe_n_o,
   output logic [NUM_CHAN-1:0]            chan_update_o
);

   logic                  rst_sync_n;
   logic [WORD_BITS-1:0]  link_word;
   logic                  select_s;
   logic                  preset_s;
   logic                  powerdown_s;
   logic [WORD_BITS-1:0]  word_q;
   logic [ADDR_BITS-1:0]  chan_sel;
   logic [5:0]            lane_base;
   odsl_state_e           state;
   odsl_state_e           next_state;

   odsl_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) u_rst_sync (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (1'b1),
      .q_o     (rst_sync_n)
   );

   // The link side has no free running clock, so it is reset asynchronously
   // by the ref domain copy; release happens while the serial clock is idle.
   odsl_shift u_shift (
      .serial_clk_i (serial_clk_i),
      .rst_n_i      (rst_sync_n),
      .select_n_i   (select_n_i),
      .serial_in_i  (serial_in_i),
      .word_o       (link_word)
   );

   odsl_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h7)
   ) u_pin_sync (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_sync_n),
      .d_i     ({select_n_i, preset_n_i, powerdown_n_i}),
      .q_o     ({select_s, preset_s, powerdown_s})
   );

   assign chan_sel  = word_q[ADDR_MSB_POS:ADDR_LSB_POS];
   assign lane_base = 6'(chan_sel) << LANE_SHIFT;

   // Assertion helper only: the one lane that a commit may touch.
   logic [NUM_CHAN*VALUE_BITS-1:0] lane_mask;

   assign lane_mask = {{(NUM_CHAN-1)*VALUE_BITS{1'b0}}, {VALUE_BITS{1'b1}}}
                      << lane_base;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (!select_s) begin
               next_state = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (select_s) begin
               next_state = ST_COMMIT;
            end
         end
         ST_COMMIT: begin
            next_state = select_s ? ST_IDLE : ST_FRAME;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The link word is held still by the raised select, so sampling it here
   // behaves as the data half of a handshake rather than a loose bus.
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         word_q <= LINK_WORD_RST;
      end else if (state == ST_FRAME && select_s) begin
         word_q <= link_word;
      end
   end

   // Preset outranks a commit in the same cycle; that word is lost.
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         channel_outputs_o <= CHAN_OUT_RST;
      end else if (!preset_s) begin
         channel_outputs_o <= {NUM_CHAN{MIDSCALE}};
      end else if (state == ST_COMMIT) begin
         channel_outputs_o[lane_base +: VALUE_BITS] <=
            word_q[VALUE_BITS-1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         chan_update_o <= UPDATE_RST;
      end else if (state == ST_COMMIT && preset_s) begin
         chan_update_o <= ONE_HOT_BASE << chan_sel;
      end else begin
         chan_update_o <= UPDATE_RST;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         channel_outputs_oe_n_o <= OE_N_RST;
      end else begin
         channel_outputs_oe_n_o <= {NUM_CHAN{~powerdown_s}};
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_sync_n);

   sequence s_frame_close;
      state == ST_FRAME && select_s;
   endsequence

   sequence s_commit_kept;
      state == ST_COMMIT && preset_s;
   endsequence

   sequence s_rise_in_frame;
      state == ST_FRAME && $rose(select_s);
   endsequence

   sequence s_preset_quiet;
      preset_s [*2];
   endsequence

   sequence s_commit_step;
      state == ST_FRAME ##1 state == ST_COMMIT;
   endsequence

   sequence s_commit_dropped;
      state == ST_COMMIT && !preset_s;
   endsequence

   sequence s_shutdown_enter;
      powerdown_s ##1 !powerdown_s;
   endsequence

   a_rise_commits: assert property (
      s_frame_close ##1 preset_s |=> chan_update_o != UPDATE_RST)
      else $error("select rise did not load a channel latch");

   a_word_captured: assert property (
      s_frame_close |=> word_q == $past(link_word))
      else $error("command word not taken from the serial register");

   a_one_latch: assert property (
      s_commit_kept |=> $onehot(chan_update_o))
      else $error("load did not enable exactly one latch");

   a_value_loaded: assert property (
      s_commit_kept |=> channel_outputs_o[$past(lane_base) +: VALUE_BITS]
                        == $past(word_q[VALUE_BITS-1:0]))
      else $error("target latch did not take the value bits");

   a_addr_decode: assert property (
      s_commit_kept |=> chan_update_o == (ONE_HOT_BASE << $past(chan_sel)))
      else $error("address decoded to the wrong channel");

   a_shutdown_open: assert property (
      !powerdown_s |=> channel_outputs_oe_n_o == {NUM_CHAN{1'b1}})
      else $error("outputs driven during shutdown");

   a_shutdown_keeps: assert property (
      !powerdown_s && preset_s && state != ST_COMMIT
      |=> $stable(channel_outputs_o))
      else $error("latch value changed during shutdown");

   a_preset_mid: assert property (
      !preset_s |=> channel_outputs_o == {NUM_CHAN{MIDSCALE}})
      else $error("preset did not load midscale");

   a_update_cause: assert property (
      chan_update_o != UPDATE_RST
      |-> $past(select_s, COMMIT_LATENCY)
          && $past(state, COMMIT_LATENCY) == ST_FRAME)
      else $error("latch load without a synchronised select rise");

   a_commit_once: assert property (
      state == ST_COMMIT |=> state != ST_COMMIT)
      else $error("commit state lasted more than one cycle");

   a_idle_holds: assert property (
      state == ST_IDLE && select_s |=> state == ST_IDLE)
      else $error("frame started while select was high");

   a_idle_to_frame: assert property (
      state == ST_IDLE && !select_s |=> state == ST_FRAME)
      else $error("low select did not open a frame");

   a_frame_only_low: assert property (
      state == ST_IDLE |=> state != ST_COMMIT)
      else $error("commit without a frame");

   a_frame_holds: assert property (
      state == ST_FRAME && !select_s |=> state == ST_FRAME)
      else $error("frame closed while select was low");

   a_commit_to_frame: assert property (
      state == ST_COMMIT && !select_s |=> state == ST_FRAME)
      else $error("back to back frame was not opened");

   a_commit_to_idle: assert property (
      state == ST_COMMIT && select_s |=> state == ST_IDLE)
      else $error("commit did not return to idle");

   a_state_legal: assert property (
      state == ST_IDLE || state == ST_FRAME
      || state == ST_COMMIT)
      else $error("state machine left its legal codes");

   a_commit_cause: assert property (
      s_commit_step |-> $past(select_s))
      else $error("commit without a synchronised select high");

   a_rise_to_load: assert property (
      s_rise_in_frame ##0 s_preset_quiet |=> chan_update_o != UPDATE_RST)
      else $error("select rise in a frame did not load a latch");

   a_word_held: assert property (
      !(state == ST_FRAME && select_s) |=> $stable(word_q))
      else $error("command word changed outside its capture");

   a_pulse_single: assert property (
      chan_update_o != UPDATE_RST |=> chan_update_o == UPDATE_RST)
      else $error("load enable stood for more than one cycle");

   a_no_stray_pulse: assert property (
      state != ST_COMMIT |=> chan_update_o == UPDATE_RST)
      else $error("load enable without a commit");

   a_others_kept: assert property (
      s_commit_kept |=> ((channel_outputs_o ^ $past(channel_outputs_o))
                        & ~$past(lane_mask)) == {NUM_CHAN*VALUE_BITS{1'b0}})
      else $error("commit disturbed a channel it did not address");

   a_latch_quiet: assert property (
      preset_s && state != ST_COMMIT |=> $stable(channel_outputs_o))
      else $error("channel latch changed without a commit");

   a_preset_wins: assert property (
      s_commit_dropped |=> chan_update_o == UPDATE_RST
                           && channel_outputs_o == {NUM_CHAN{MIDSCALE}})
      else $error("commit during preset was not dropped");

   a_preset_no_pulse: assert property (
      !preset_s |=> chan_update_o == UPDATE_RST)
      else $error("load enable pulsed during preset");

   a_preset_keeps: assert property (
      (!preset_s) [*2] |=> $stable(channel_outputs_o))
      else $error("latches moved while preset was held");

   a_oe_uniform: assert property (
      channel_outputs_oe_n_o == {NUM_CHAN{1'b0}}
      || channel_outputs_oe_n_o == {NUM_CHAN{1'b1}})
      else $error("channel output enables disagree");

   a_shutdown_steps: assert property (
      s_shutdown_enter
      |=> channel_outputs_oe_n_o != $past(channel_outputs_oe_n_o))
      else $error("entering shutdown did not open the outputs");

   a_resume_drive: assert property (
      powerdown_s |=> channel_outputs_oe_n_o == {NUM_CHAN{1'b0}})
      else $error("outputs not driven after shutdown");

endmodule

// ==== odsl_ctl_model.sv ====
// Behavioural model of the controller that drives the serial link.
// Assumes the bench calls its tasks from one process at a time.
module odsl_ctl_model (
   output logic serial_clk_o,
   output logic select_n_o,
   output logic serial_in_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      serial_clk_o = 1'b1;
      select_n_o   = 1'b1;
      serial_in_o  = 1'b0;
   end

   // Here the clock only runs inside a frame and rests high after it; idle_clocks runs it between frames.
   task automatic send(input logic [15:0] word, input int nbits,
                       input int half);
      select_n_o = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_in_o = word[i];
         #(half / 2) serial_clk_o = 1'b0;
         #(half) serial_clk_o = 1'b1;
         #(half / 2);
      end
      // A released data line shows the inverse, not a stale copy.
      serial_in_o = ~serial_in_o;
      select_n_o  = 1'b1;
   endtask

   task automatic idle_clocks(input int n);
      repeat (n) begin
         serial_in_o = ~serial_in_o;
         #8 serial_clk_o = 1'b0;
         #16 serial_clk_o = 1'b1;
         #8;
      end
   endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the octal DAC serial loader.
// Assumes the design package and the controller model are compiled first.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top
   import odsl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic                           ref_clk;
   logic                           rst_n;
   logic                           serial_clk;
   logic                           select_n;
   logic                           serial_in;
   logic                           preset_n;
   logic                           powerdown_n;
   logic [NUM_CHAN*VALUE_BITS-1:0] channel_outputs_o;
   logic [NUM_CHAN-1:0]            oe_n;
   logic [NUM_CHAN-1:0]            chan_update_o;
   logic [NUM_CHAN*VALUE_BITS-1:0] exp_bus;
   int                             fails;
   int                             samples_checked;

   odsl_top DUT (
      .ref_clk_i              (ref_clk),
      .rst_n_i                (rst_n),
      .serial_clk_i           (serial_clk),
      .select_n_i             (select_n),
      .serial_in_i            (serial_in),
      .preset_n_i             (preset_n),
      .powerdown_n_i          (powerdown_n),
      .channel_outputs_o      (channel_outputs_o),
      .channel_outputs_oe_n_o (oe_n),
      .chan_update_o          (chan_update_o)
   );

   odsl_ctl_model ctl (
      .serial_clk_o (serial_clk),
      .select_n_o   (select_n),
      .serial_in_o  (serial_in)
   );

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The pulse stands one cycle, so it is polled on every falling edge.
   task automatic write_chk(input logic [2:0] addr, input logic [7:0] val,
                            input logic [4:0] junk, input int nbits,
                            input int half);
      ctl.send({junk, addr, val}, nbits, half);
      exp_bus[8*addr +: 8] = val;
      repeat (12) begin
         @(negedge ref_clk);
         if (chan_update_o !== 8'h00) break;
      end
      `CHK(chan_update_o, ONE_HOT_BASE << addr)
      `CHK(channel_outputs_o, exp_bus)
      @(negedge ref_clk);
      `CHK(chan_update_o, 8'h00)
   endtask

   task automatic sc_all_chan();
      for (int a = 0; a < NUM_CHAN; a++) begin
         write_chk(3'(a), 8'h3c ^ 8'(a * 8'h25), 5'h00, 11,
                   (a == 7) ? 50 : 16);
      end
   endtask

   task automatic sc_long_word();
      write_chk(3'h5, 8'hc3, 5'h1f, 16, 16);
      write_chk(3'h2, 8'h01, 5'h15, 14, 16);
   endtask

   task automatic sc_idle_clock();
      ctl.idle_clocks(6);
      repeat (8) begin
         @(negedge ref_clk);
         `CHK(chan_update_o, 8'h00)
      end
      `CHK(channel_outputs_o, exp_bus)
      // A one-bit frame reuses the held word, so a stray idle shift shows.
      write_chk(3'h4, 8'h03, 5'h00, 1, 50);
   endtask

   task automatic sc_shutdown();
      powerdown_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      `CHK(oe_n, 8'hff)
      `CHK(channel_outputs_o, exp_bus)
      powerdown_n = 1'b1;
      repeat (6) @(negedge ref_clk);
      `CHK(oe_n, 8'h00)
   endtask

   task automatic sc_preset();
      preset_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      `CHK(channel_outputs_o, {NUM_CHAN{8'h80}})
      preset_n = 1'b1;
      exp_bus  = {NUM_CHAN{8'h80}};
      repeat (4) @(negedge ref_clk);
      write_chk(3'h0, 8'hff, 5'h00, 11, 16);
   endtask

   initial begin
      #100000;
      fails++;
      end_sim();
   end

   initial begin
      fails           = 0;
      samples_checked = 0;
      rst_n           = 1'b0;
      preset_n        = 1'b1;
      powerdown_n     = 1'b1;
      exp_bus         = {NUM_CHAN{8'h80}};
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (5) @(negedge ref_clk);
      `CHK(channel_outputs_o, exp_bus)
      `CHK(oe_n, 8'h00)
      sc_all_chan();
      sc_long_word();
      sc_idle_clock();
      sc_shutdown();
      sc_preset();
      end_sim();
   end
endmodule
